// File: pcfg_header.sv
/*
 * Configuration header slice: revision and class word, cache line
 * size, latency timer, reserved half word and mailbox base register,
 * plus the mailbox window decode.
 * Assumes one-cycle configuration request pulses on the PCI clock.
 */
// Function
// - Revision byte at 0x108 is read only and returns a fixed value.
// - Class code fills bits 31:8 of the word holding the revision.
// - Class code reads zero interface, zero subclass, base class 0x06.
// - Byte 0x10C reads a fixed cache line size of 0x04.
// - Byte 0x10D is the readable and writable master latency timer.
// - Latency bits 10:8 read zero; only bits 15:11 store a value.
// - Bytes at 0x10E read zero and ignore writes.
// - Word 0x110 is the readable and writable mailbox base register.
// - Base register bits 11:0 read zero: 32-bit, 4-KB, no prefetch.
// - Base bits 31:12 hold the writable window address.
// - Address bit 11 picks the mailbox; zero is the first one.
`timescale 1ns/1ns
module pcfg_header import pcfg_pkg::*; #(
    // Arbitrary revision value
    parameter logic [7:0] REVISION_VALUE = 8'h5a
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              cfg_req,
    input  wire logic              cfg_we,
    input  wire logic [CFG_AW-1:0] cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic [31:0]            cfg_rdata,
    output logic                   cfg_ack,
    output logic [7:0]             master_latency_timer,
    input  wire logic              mem_valid,
    input  wire logic [31:0]       mem_addr,
    output logic                   mailbox_hit,
    output logic                   mailbox_select_bit
);
    pcfg_mbx_if mbx ();

    logic [LAT_W-1:0] lat;
    logic [MBX_W-1:0] base;
    logic [31:0]      rdata;
    logic             ack;
    logic [LAT_W-1:0] next_lat;
    logic [MBX_W-1:0] next_base;
    logic [31:0]      next_rdata;
    logic             next_ack;
    logic [11:0]      word;
    logic             wr;
    logic             rd;

    assign word = cfg_addr & WORD_MASK;
    assign wr   = cfg_req && cfg_we;
    assign rd   = cfg_req && !cfg_we;

    always_comb begin
        next_lat   = lat;
        next_base  = base;
        next_rdata = rdata;
        next_ack   = cfg_req;
        // Writes elsewhere in the slice are acknowledged and dropped
        if (wr && word == OFF_CLINE_SIZE && cfg_be[BE_LAT]) begin
            next_lat = cfg_wdata[LAT_LSB +: LAT_W];
        end
        if (wr && word == OFF_MBX_BASE) begin
            for (int b = 1; b < 4; b++) begin
                if (cfg_be[b]) begin
                    for (int i = 8*b; i < 8*b+8; i++) begin
                        if (i >= MBX_LSB) begin
                            next_base[i-MBX_LSB] = cfg_wdata[i];
                        end
                    end
                end
            end
        end
        if (rd) begin
            next_rdata = 32'h00000000;
            unique case (word)
                OFF_REVISION: begin
                    next_rdata = {BASE_CLASS_VALUE, SUBCLASS_VALUE,
                                  PROG_IF_VALUE, REVISION_VALUE};
                end
                OFF_CLINE_SIZE: begin
                    next_rdata = {16'h0000, lat, 3'h0,
                                  CLINE_SIZE_VALUE};
                end
                OFF_MBX_BASE: begin
                    next_rdata = {base, 12'h000};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lat   <= LAT_RESET;
            base  <= MBX_RESET;
            rdata <= 32'h00000000;
            ack   <= 1'b0;
        end else begin
            lat   <= next_lat;
            base  <= next_base;
            rdata <= next_rdata;
            ack   <= next_ack;
        end
    end

    assign cfg_rdata            = rdata;
    assign cfg_ack              = ack;
    assign master_latency_timer = {lat, 3'h0};

    // Base is assumed stable during mailbox accesses by the host
    assign mbx.mailbox_base_field = base;
    assign mbx.mem_valid          = mem_valid;
    assign mbx.mem_addr           = mem_addr;
    assign mailbox_hit            = mbx.mailbox_hit;
    assign mailbox_select_bit     = mbx.mailbox_select_bit;

    pcfg_mbx_decode u_dec (
        .core_clk (core_clk),
        .rst      (rst),
        .mbx      (mbx)
    );

    sequence s_read(logic [11:0] w);
        cfg_req && !cfg_we && (cfg_addr & WORD_MASK) == w;
    endsequence
    sequence s_write(logic [11:0] w);
        cfg_req && cfg_we && (cfg_addr & WORD_MASK) == w;
    endsequence

    AST_ID_WORD: assert property (@(posedge core_clk) disable iff (rst)
        s_read(OFF_REVISION) |=> cfg_ack && cfg_rdata ==
        {BASE_CLASS_VALUE, SUBCLASS_VALUE, PROG_IF_VALUE, REVISION_VALUE})
        else $error("identification word wrong");

    AST_CLINE_WORD: assert property (@(posedge core_clk) disable iff (rst)
        s_read(OFF_CLINE_SIZE) |=> cfg_rdata[7:0] == CLINE_SIZE_VALUE &&
        cfg_rdata[10:8] == 3'h0 && cfg_rdata[31:16] == 16'h0000)
        else $error("cache line word wrong");

    AST_LAT_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_write(OFF_CLINE_SIZE) ##0 cfg_be[BE_LAT] ##1 !cfg_req
        ##1 s_read(OFF_CLINE_SIZE)
        |=> cfg_rdata[15:11] == $past(cfg_wdata[15:11], 3))
        else $error("latency timer write not read back");

    AST_BASE_LOW: assert property (@(posedge core_clk) disable iff (rst)
        s_read(OFF_MBX_BASE) |=> cfg_rdata[11:0] == 12'h000)
        else $error("base register low bits not zero");

    AST_BASE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_write(OFF_MBX_BASE) ##0 cfg_be[3] |=>
        mbx.mailbox_base_field[19:12] == $past(cfg_wdata[31:24]))
        else $error("base register write lost");

    AST_RO_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_write(OFF_REVISION) |=> $stable(lat) && $stable(base) ##0 cfg_ack)
        else $error("write to fixed word changed state");

    AST_ACK_ONE: assert property (@(posedge core_clk) disable iff (rst)
        cfg_req |=> cfg_ack ##0 1'b1)
        else $error("request not acknowledged");

    AST_BASE_B2: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write(OFF_MBX_BASE) ##0 cfg_be[2] |=>
        base[11:4] == $past(cfg_wdata[23:16]))
        else $error("base register byte two lost");

    AST_BASE_B1: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write(OFF_MBX_BASE) ##0 cfg_be[1] |=>
        base[3:0] == $past(cfg_wdata[15:12]))
        else $error("base register byte one lost");

    AST_BASE_KEEP: assert property (
        @(posedge core_clk) disable iff (rst)
        !(cfg_req && cfg_we && (cfg_addr & WORD_MASK) == OFF_MBX_BASE)
        |=> $stable(base))
        else $error("base register changed without a write");

    AST_LAT_KEEP: assert property (
        @(posedge core_clk) disable iff (rst)
        !(cfg_req && cfg_we && (cfg_addr & WORD_MASK) == OFF_CLINE_SIZE &&
          cfg_be[BE_LAT]) |=> $stable(lat))
        else $error("latency timer changed without a write");

    AST_LAT_PORT: assert property (
        @(posedge core_clk) disable iff (rst)
        s_read(OFF_CLINE_SIZE) |=> cfg_rdata[15:8] == master_latency_timer)
        else $error("latency port disagrees with read value");

    AST_CLASS_ALIAS: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_req && !cfg_we && cfg_addr == OFF_CLASS_CODE |=>
        cfg_rdata[31:8] == {BASE_CLASS_VALUE, SUBCLASS_VALUE, PROG_IF_VALUE})
        else $error("class code read at its own offset wrong");

    AST_UNMAPPED: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_req && !cfg_we && (cfg_addr & WORD_MASK) != OFF_REVISION &&
        (cfg_addr & WORD_MASK) != OFF_CLINE_SIZE &&
        (cfg_addr & WORD_MASK) != OFF_MBX_BASE |=> cfg_rdata == 32'h00000000)
        else $error("unmapped word read not zero");

    AST_RDATA_HOLD: assert property (
        @(posedge core_clk) disable iff (rst)
        !(cfg_req && !cfg_we) |=> $stable(cfg_rdata))
        else $error("read data moved without a read");

    AST_ACK_ONLY: assert property (
        @(posedge core_clk) disable iff (rst)
        !cfg_req |=> !cfg_ack)
        else $error("acknowledge without a request");

    AST_RO_LINE: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write(OFF_CLINE_SIZE) |=> $stable(base) && cfg_ack)
        else $error("write to line size word disturbed the base");

    AST_RSVD_WRITE: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_req && cfg_we && cfg_addr == OFF_RSVD_HALF && !cfg_be[BE_LAT]
        |=> $stable(lat))
        else $error("write to reserved bytes moved the latency timer");
endmodule

// File: pcfg_host_model.sv
/*
 * Host model: issues configuration and memory cycles to the header slice.
 * Assumes the bench shares core_clk and calls one task at a time.
 */
`timescale 1ns/1ns
module pcfg_host_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_ack,
    input  wire logic        mailbox_hit,
    input  wire logic        mailbox_select_bit,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic [11:0]      cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    output logic             mem_valid,
    output logic [31:0]      mem_addr
);
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 12'h000;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
        mem_valid = 1'b0;
        mem_addr = 32'h00000000;
    end

    task automatic cfg(input logic we, input logic [11:0] a,
                       input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
        @(posedge core_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_req <= 1'b0;
        cfg_wdata <= ~d;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            ok = (cfg_ack === 1'b1);
            if (!ok)
                @(posedge core_clk);
        end
        q = cfg_rdata;
    endtask

    // Calls never overlap, so the base stays still during an access
    task automatic mem(input logic [31:0] a, output logic h, output logic s);
        @(posedge core_clk);
        mem_valid <= 1'b1;
        mem_addr <= a;
        @(posedge core_clk);
        mem_valid <= 1'b0;
        mem_addr <= ~a;
        #1;
        h = mailbox_hit;
        s = mailbox_select_bit;
    endtask
endmodule

// File: pcfg_mbx_decode.sv
/*
 * Mailbox window decoder: compares a memory address with the
 * programmed base and reports hit and mailbox number one cycle later.
 * Assumes the base is not rewritten during a mailbox access.
 */
`timescale 1ns/1ns
module pcfg_mbx_decode import pcfg_pkg::*; (
    input  wire logic core_clk,
    input  wire logic rst,
    pcfg_mbx_if.dec   mbx
);
    logic next_hit;
    logic next_sel;
    logic hit;
    logic sel;

    always_comb begin
        next_hit = mbx.mem_valid &&
            (mbx.mem_addr[31:MBX_LSB] == mbx.mailbox_base_field);
        next_sel = mbx.mem_addr[MBX_SEL_BIT];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hit <= 1'b0;
            sel <= 1'b0;
        end else begin
            hit <= next_hit;
            sel <= next_sel;
        end
    end

    assign mbx.mailbox_hit        = hit;
    assign mbx.mailbox_select_bit = sel;

    AST_MBX_HIT: assert property (@(posedge core_clk) disable iff (rst)
        mbx.mem_valid && mbx.mem_addr[31:MBX_LSB] == mbx.mailbox_base_field
        |=> mbx.mailbox_hit)
        else $error("mailbox window access not flagged as hit");

    AST_MBX_MISS: assert property (@(posedge core_clk) disable iff (rst)
        !mbx.mem_valid |=> !mbx.mailbox_hit)
        else $error("hit flagged without a memory access");

    AST_MBX_SEL: assert property (@(posedge core_clk) disable iff (rst)
        mbx.mem_valid |=>
        mbx.mailbox_select_bit == $past(mbx.mem_addr[MBX_SEL_BIT]))
        else $error("mailbox number does not follow address bit");
endmodule

// File: pcfg_mbx_if.sv
/*
 * Carrier between the header registers and the mailbox decoder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface pcfg_mbx_if import pcfg_pkg::*; ();
    logic [MBX_W-1:0] mailbox_base_field;
    logic             mem_valid;
    logic [31:0]      mem_addr;
    logic             mailbox_hit;
    logic             mailbox_select_bit;

    modport regs (output mailbox_base_field, mem_valid, mem_addr,
                  input  mailbox_hit, mailbox_select_bit);
    modport dec  (input  mailbox_base_field, mem_valid, mem_addr,
                  output mailbox_hit, mailbox_select_bit);
endinterface

// File: pcfg_pkg.sv
/*
 * Constants for the configuration header slice: offsets, field layout,
 * fixed field values and reset values.
 * Assumes configuration offsets are 12-bit byte offsets into the header.
 */
package pcfg_pkg;
    localparam int          CFG_AW         = 12;
    localparam logic [11:0] WORD_MASK      = 12'hffc;
    localparam logic [11:0] OFF_REVISION   = 12'h108;
    localparam logic [11:0] OFF_CLASS_CODE = 12'h109;
    localparam logic [11:0] OFF_CLINE_SIZE = 12'h10c;
    localparam logic [11:0] OFF_LATENCY    = 12'h10d;
    localparam logic [11:0] OFF_RSVD_HALF  = 12'h10e;
    localparam logic [11:0] OFF_MBX_BASE   = 12'h110;

    localparam logic [7:0]  PROG_IF_VALUE    = 8'h00;
    localparam logic [7:0]  SUBCLASS_VALUE   = 8'h00;
    localparam logic [7:0]  BASE_CLASS_VALUE = 8'h06;
    localparam logic [7:0]  CLINE_SIZE_VALUE = 8'h04;

    localparam int          LAT_LSB     = 11;
    localparam int          LAT_W       = 5;
    localparam logic [4:0]  LAT_RESET   = 5'h00;
    localparam int          MBX_LSB     = 12;
    localparam int          MBX_W       = 20;
    localparam logic [19:0] MBX_RESET   = 20'h00000;
    localparam int          MBX_SEL_BIT = 11;
    localparam int          BE_LAT      = 1;
endpackage

// File: tb_pcfg_header.sv
/*
 * Testbench for the header slice against an integer reference model.
 * Assumes the host model drives every bus input of the design.
 */
`timescale 1ns/1ns
module tb_pcfg_header import pcfg_pkg::*;;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cfg_req, cfg_we, cfg_ack, mem_valid, hit, sel;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be, be;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr, q, d, a;
    logic [7:0]  mlt;
    logic [4:0]  lat = 5'h00;
    logic [19:0] mb = 20'h00000;
    logic        ok, h, s;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          seed = 32'h5b56b1b1;

    always #5 core_clk = ~core_clk;

    pcfg_header #(.REVISION_VALUE(REV)) uut (.core_clk(core_clk), .rst(rst),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .master_latency_timer(mlt),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mailbox_hit(hit),
        .mailbox_select_bit(sel));
    pcfg_host_model host (.core_clk(core_clk), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .mailbox_hit(hit), .mailbox_select_bit(sel),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .mem_valid(mem_valid),
        .mem_addr(mem_addr));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One bus access; the model tracks what a write should store
    task automatic acc(input logic we, input logic [11:0] ad,
                       input logic [3:0] b, input logic [31:0] dd);
        host.cfg(we, ad, b, dd, q, ok);
        if (!ok) begin
            n_mismatch++;
            print_verdict();
        end
        if (we && ad[11:2] == OFF_LATENCY[11:2] && b[1])
            lat = dd[15:11];
        if (we && ad[11:2] == OFF_MBX_BASE[11:2]) begin
            if (b[1]) mb[3:0] = dd[15:12];
            if (b[2]) mb[11:4] = dd[23:16];
            if (b[3]) mb[19:12] = dd[31:24];
        end
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        acc(1'b0, OFF_CLINE_SIZE, 4'hf, 32'h0);
        chk("line_word_rst", 32'h00000004, q);
        acc(1'b0, OFF_MBX_BASE, 4'hf, 32'h0);
        chk("base_rst", 32'h0, q);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, OFF_REVISION, 4'hf, $random(seed));
            acc(1'b0, i == 0 ? OFF_REVISION : OFF_CLASS_CODE, 4'hf, 32'h0);
            chk("id_word", {BASE_CLASS_VALUE, 16'h0, REV}, q);
        end
        acc(1'b1, 12'h114, 4'hf, 32'hffffffff);
        acc(1'b0, 12'h114, 4'hf, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test id done");
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            be = 4'($random(seed));
            acc(1'b1, OFF_CLINE_SIZE + 12'(i % 3), be, d);
            acc(1'b0, OFF_RSVD_HALF, 4'hf, 32'h0);
            chk("lat_word", {16'h0, lat, 3'h0, CLINE_SIZE_VALUE}, q);
            chk("lat_port", {24'h0, lat, 3'h0}, {24'h0, mlt});
        end
        $display("test latency done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            be = (i < 2) ? 4'hf : 4'($random(seed));
            acc(1'b1, OFF_MBX_BASE, be, d);
            acc(1'b0, OFF_MBX_BASE, 4'hf, 32'h0);
            chk("base_word", {mb, 12'h0}, q);
            a = {mb ^ 20'(i % 2), 12'($random(seed))};
            host.mem(a, h, s);
            chk("mbx_hit", 32'(i % 2 == 0), 32'(h));
            chk("mbx_sel", 32'(a[11]), 32'(s));
        end
        $display("test mailbox done");
        print_verdict();
    end
endmodule
